/* File: testbench/fadc_capture_model.sv */
// capture logic on the far side of the converter's three-state result bus
module fadc_capture_model (
    input  wire logic       mclk,
    input  wire logic       samp_clk,
    input  wire logic [7:0] result_bits,
    input  wire logic [7:0] result_oe,
    input  wire logic       overrange_flag,
    input  wire logic       overrange_flag_oe,
    output logic      [7:0] pin_data,
    output logic            pin_flag,
    output logic      [8:0] captured_reg
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0] last_reg;
    logic       samp_d_reg;
    // ------------------------------------------------------------------
    // wire levels
    // ------------------------------------------------------------------
    // no pull on these lines: a floating pin shows the inverse of its last driven level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_data[i] = result_oe[i] ? result_bits[i] : ~last_reg[i];
        end
        pin_flag = overrange_flag_oe ? overrange_flag : ~last_reg[8];
    end
    // ------------------------------------------------------------------
    // capture on the falling sampling clock
    // ------------------------------------------------------------------
    initial begin
        last_reg     <= 9'h000;
        samp_d_reg   <= 1'b0;
        captured_reg <= 9'h000;
    end
    always @(posedge mclk) begin
        // only a driven pin refreshes the remembered level
        for (int i = 0; i < 8; i++) begin
            if (result_oe[i]) begin
                last_reg[i] <= result_bits[i];
            end
        end
        if (overrange_flag_oe) begin
            last_reg[8] <= overrange_flag;
        end
        samp_d_reg <= samp_clk;
        if (samp_d_reg && !samp_clk) begin
            captured_reg <= {pin_flag, pin_data};
        end
    end
endmodule // fadc_capture_model

/* File: testbench/flash_adc_output_port_bench.sv */
// self-checking bench of the flash converter output port
module flash_adc_output_port_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic           mclk, rst_b, samp_clk, cmp_over;
    logic [254:0]   cmp_thermo;
    logic           oel, oel_drv, oeh, oeh_drv;
    logic [7:0]     result_bits, result_oe, pin_data;
    logic           overrange_flag, overrange_flag_oe, result_valid, pin_flag;
    logic [8:0]     exp_q[$];
    logic [8:0]     exp_v;
    logic [8:0]     exp_o, last_v, captured;
    logic           have_last;
    int             miscompares, n_compared, seed, n;
    logic           sc_d, fell, pend;
    // ------------------------------------------------------------------
    // design and far side
    // ------------------------------------------------------------------
    fadc_port uut (.mclk(mclk), .rst_b(rst_b), .samp_clk(samp_clk),
        .cmp_thermo(cmp_thermo), .cmp_over(cmp_over),
        .output_enable_low_active(oel), .output_enable_low_active_drv(oel_drv),
        .output_enable_high_active(oeh), .output_enable_high_active_drv(oeh_drv),
        .result_bits(result_bits), .result_oe(result_oe),
        .overrange_flag(overrange_flag), .overrange_flag_oe(overrange_flag_oe),
        .result_valid(result_valid));
    fadc_capture_model cap (.mclk(mclk), .samp_clk(samp_clk), .result_bits(result_bits),
        .result_oe(result_oe), .overrange_flag(overrange_flag),
        .overrange_flag_oe(overrange_flag_oe), .pin_data(pin_data), .pin_flag(pin_flag),
        .captured_reg(captured));
    initial mclk = 1'b0;
    always #4 mclk = ~mclk;
    // ------------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------------
    task automatic tally(input string what, input logic [8:0] e, input logic [8:0] s);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, e, s);
        end
    endtask
    task automatic chk_code(input string what, input logic [8:0] e, input logic [8:0] s);
        tally(what, e, s);
    endtask
    task automatic chk_oe(input string what, input logic [8:0] e, input logic [8:0] s);
        tally(what, e, s);
    endtask
    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // a result lands on the mclk that samples the fall of the sampling clock and is checked one mclk later
    always @(posedge mclk) begin
        fell = sc_d && !samp_clk;
        sc_d = samp_clk;
        if (pend && result_valid === 1'b1 && exp_q.size() > 0) begin
            #1;
            exp_o = exp_q.pop_front();
            chk_code("result", exp_o, {overrange_flag, result_bits});
            chk_code("pins", exp_o, {pin_flag, pin_data});
            // the far side latched at this fall what the pins held before it
            if (have_last) begin
                chk_code("capture", last_v, captured);
            end
            last_v = exp_o;
            have_last = 1'b1;
        end
        pend = fell;
    end
    initial begin
        #(3000 * 8);
        miscompares++;
        $display("watchdog expired");
        end_of_test();
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        miscompares = 0;
        n_compared = 0;
        seed = 29;
        sc_d = 1'b0;
        pend = 1'b0;
        have_last = 1'b0;
        rst_b <= 1'b0;
        samp_clk <= 1'b0;
        cmp_thermo <= '0;
        cmp_over <= 1'b0;
        {oel, oel_drv, oeh, oeh_drv} <= 4'h0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        #1;
        chk_code("reset result", 9'h000, {overrange_flag, result_bits});
        chk_code("reset valid", 9'h000, {8'h00, result_valid});
        $display("reset test done");
        // every level and drive combination of the two enables
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk);
            {oel, oel_drv, oeh, oeh_drv} <= i[3:0];
            @(posedge mclk);
            #1;
            exp_v[7:0] = (oeh_drv ? oeh : 1'b1) ? 8'hFF : 8'h00;
            exp_v[8] = (oeh_drv ? oeh : 1'b1) && !(oel_drv ? oel : 1'b0);
            chk_oe("enables", exp_v, {overrange_flag_oe, result_oe});
        end
        $display("enable test done");
        @(posedge mclk);
        {oel, oel_drv, oeh, oeh_drv} <= 4'h0;
        // inputs change with the fall and stay put through the aperture count
        for (int k = 0; k < 24; k++) begin
            n = (k == 0) ? 255 : (k == 1) ? 0 : ($unsigned($random(seed)) % 256);
            exp_v = {1'(($random(seed) >>> 3) & 1), n[7:0]};
            @(posedge mclk);
            samp_clk <= 1'b0;
            cmp_thermo <= (n == 0) ? '0 : ({255{1'b1}} >> (255 - n));
            cmp_over <= exp_v[8];
            exp_q.push_back(exp_v);
            // 13 low plus 12 high mclk periods: 200 ns, the fastest allowed sampling clock
            repeat (13) @(posedge mclk);
            samp_clk <= 1'b1;
            repeat (11) @(posedge mclk);
        end
        // two more periods flush the last samples through the pipeline
        repeat (2) begin
            @(posedge mclk);
            samp_clk <= 1'b0;
            repeat (13) @(posedge mclk);
            samp_clk <= 1'b1;
            repeat (11) @(posedge mclk);
        end
        repeat (4) @(posedge mclk);
        chk_code("left in queue", 9'h000, 9'(exp_q.size()));
        $display("conversion test done");
        end_of_test();
    end
endmodule // flash_adc_output_port_bench

/* File: verilog/fadc_enc_if.sv */
// carrier between the conversion core and the thermometer encoder
interface fadc_enc_if #(
    parameter int NUM_CMP = 255,
    parameter int RES_W   = 8
);
    logic [NUM_CMP-1:0] thermo;
    logic               over_cmp;
    logic [RES_W-1:0]   code;
    logic               over_flag;

    modport core (output thermo, output over_cmp, input code, input over_flag);
    modport enc  (input thermo, input over_cmp, output code, output over_flag);
endinterface

/* File: verilog/fadc_encoder.sv */
// thermometer to binary encoder with a separate overrange path
module fadc_encoder
    import fadc_pkg::*;
#(
    parameter int NUM_CMP = 255,
    parameter int RES_W   = 8
) (
    fadc_enc_if.enc bus
);
    // -----------------------------------------------------------------------
    // encoding
    // -----------------------------------------------------------------------
    // counting ones tolerates a bubble in the thermometer code, unlike a
    // single transition search, at the cost of a wider adder tree
    always_comb begin
        logic [RES_W-1:0] cnt;
        cnt = '0;
        for (int i = 0; i < NUM_CMP; i++) begin
            cnt = cnt + RES_W'(bus.thermo[i]);
        end
        bus.code = cnt;
    end

    // the overrange comparator never enters the code sum
    assign bus.over_flag = bus.over_cmp;
endmodule // fadc_encoder

/* File: verilog/fadc_params.svh */
// constants of the flash converter output port: widths, bit positions, timing counts
`ifndef FADC_PARAMS_SVH
`define FADC_PARAMS_SVH

// ---------------------------------------------------------------------------
// widths, bit positions and code values
// ---------------------------------------------------------------------------
`define FADC_RES_W          8
`define FADC_NUM_CMP        255
`define FADC_RESULT_MSB     7
`define FADC_RESULT_LSB     0
`define FADC_CODE_TOP       8'hFF
`define FADC_CODE_RST       8'h00

// ---------------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------------
`define FADC_MCLK_NS        8
`define FADC_APERTURE_NS    25
// fixed delay, rounded down to whole cycles, never below one
`define FADC_APERTURE_CYC   (((`FADC_APERTURE_NS / `FADC_MCLK_NS) < 1) ? 1 : \
                             (`FADC_APERTURE_NS / `FADC_MCLK_NS))
`define FADC_AP_CNT_W       4
`define FADC_AP_CNT_RST     4'h0

`endif

/* File: verilog/fadc_pkg.sv */
// types shared by the flash converter output port modules
package fadc_pkg;

    // -----------------------------------------------------------------------
    // comparator phase seen from the sampling clock
    // -----------------------------------------------------------------------
    typedef enum logic {
        FADC_PH_SAMPLE,
        FADC_PH_BALANCE
    } fadc_phase_t;

endpackage

/* File: verilog/fadc_port.sv */
// digital side of the 8-bit flash converter: sampling phases, pipeline, output buffers
`include "fadc_params.svh"

// Contract
// - the result is eight bits wide with bit seven the most and bit zero the least significant.
// - the 255 thermometer comparator outputs are encoded into one of 256 binary codes.
// - the overrange flag comes from a 256th comparator kept apart from the data comparators.
// - each result appears one and a half sampling periods after the sample it belongs to.
// - once per sampling period the comparator latch moves to the output path as the input is sampled.
// - sampling clock high is the balance phase and sampling clock low is the sample phase.
// - the sample phase ends at the sampling clock rising edge after a fixed aperture delay.
// - result and flag leave through three-state buffers that can float.
// - an unconnected low-active enable reads low and an unconnected high-active enable reads high.
// - enables act without the clock; high-active low floats all, else result drives, flag needs both.
// - the overrange flag never alters the data code, which saturates at its top value.
module fadc_port
    import fadc_pkg::*;
#(
    parameter int NUM_CMP  = `FADC_NUM_CMP,
    parameter int RES_W    = `FADC_RES_W,
    parameter int AP_CYC   = `FADC_APERTURE_CYC,
    parameter int AP_CNT_W = `FADC_AP_CNT_W
) (
    input  wire logic               mclk,
    input  wire logic               rst_b,
    input  wire logic               samp_clk,
    input  wire logic [NUM_CMP-1:0] cmp_thermo,
    input  wire logic               cmp_over,
    input  wire logic               output_enable_low_active,
    input  wire logic               output_enable_low_active_drv,
    input  wire logic               output_enable_high_active,
    input  wire logic               output_enable_high_active_drv,
    output logic [RES_W-1:0]        result_bits,
    output logic [RES_W-1:0]        result_oe,
    output logic                    overrange_flag,
    output logic                    overrange_flag_oe,
    output logic                    result_valid
);
    // follows the parameter so the aperture check stays right when AP_CYC is overridden
    localparam int AP_DLY = AP_CYC;

    // -----------------------------------------------------------------------
    // sampling phases
    // -----------------------------------------------------------------------
    fadc_phase_t phase_reg;
    fadc_phase_t phase_next;
    logic        rise_evt;
    logic        fall_evt;

    always_comb begin
        phase_next = samp_clk ? FADC_PH_BALANCE : FADC_PH_SAMPLE;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            phase_reg <= FADC_PH_SAMPLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    assign rise_evt = samp_clk && (phase_reg == FADC_PH_SAMPLE);
    assign fall_evt = !samp_clk && (phase_reg == FADC_PH_BALANCE);

    // -----------------------------------------------------------------------
    // aperture delay
    // -----------------------------------------------------------------------
    logic [AP_CNT_W-1:0] ap_cnt_reg;
    logic [AP_CNT_W-1:0] ap_cnt_next;
    logic                ap_hit;

    assign ap_hit = (ap_cnt_reg == AP_CNT_W'(1));

    always_comb begin
        ap_cnt_next = ap_cnt_reg;
        if (rise_evt) begin
            ap_cnt_next = AP_CNT_W'(AP_CYC);
        end else if (ap_cnt_reg != '0) begin
            ap_cnt_next = ap_cnt_reg - AP_CNT_W'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ap_cnt_reg <= `FADC_AP_CNT_RST;
        end else begin
            ap_cnt_reg <= ap_cnt_next;
        end
    end

    // -----------------------------------------------------------------------
    // conversion pipeline
    // -----------------------------------------------------------------------
    // the latch is loaded when the aperture closes; in the same cycle the
    // previous latch contents, encoded, move on, so a sample reaches the pins
    // at the falling edge one period later: 1.5 periods in all
    fadc_enc_if #(.NUM_CMP(NUM_CMP), .RES_W(RES_W)) enc_bus ();

    logic [NUM_CMP-1:0] latch_reg;
    logic [NUM_CMP-1:0] latch_next;
    logic               latch_ovr_reg;
    logic               latch_ovr_next;
    logic [RES_W-1:0]   enc_reg;
    logic [RES_W-1:0]   enc_next;
    logic               enc_ovr_reg;
    logic               enc_ovr_next;
    logic [RES_W-1:0]   out_reg;
    logic [RES_W-1:0]   out_next;
    logic               out_ovr_reg;
    logic               out_ovr_next;
    logic               latch_full_reg;
    logic               latch_full_next;
    logic               enc_full_reg;
    logic               enc_full_next;
    logic               valid_reg;
    logic               valid_next;

    assign enc_bus.thermo   = latch_reg;
    assign enc_bus.over_cmp = latch_ovr_reg;

    fadc_encoder #(.NUM_CMP(NUM_CMP), .RES_W(RES_W)) u_enc (
        .bus (enc_bus.enc)
    );

    always_comb begin
        latch_next      = latch_reg;
        latch_ovr_next  = latch_ovr_reg;
        enc_next        = enc_reg;
        enc_ovr_next    = enc_ovr_reg;
        out_next        = out_reg;
        out_ovr_next    = out_ovr_reg;
        latch_full_next = latch_full_reg;
        enc_full_next   = enc_full_reg;
        valid_next      = valid_reg;
        if (ap_hit) begin
            latch_next      = cmp_thermo;
            latch_ovr_next  = cmp_over;
            enc_next        = enc_bus.code;
            enc_ovr_next    = enc_bus.over_flag;
            latch_full_next = 1'b1;
            enc_full_next   = latch_full_reg;
        end
        if (fall_evt) begin
            out_next     = enc_reg;
            out_ovr_next = enc_ovr_reg;
            valid_next   = enc_full_reg;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            latch_reg      <= '0;
            latch_ovr_reg  <= 1'b0;
            enc_reg        <= `FADC_CODE_RST;
            enc_ovr_reg    <= 1'b0;
            out_reg        <= `FADC_CODE_RST;
            out_ovr_reg    <= 1'b0;
            latch_full_reg <= 1'b0;
            enc_full_reg   <= 1'b0;
            valid_reg      <= 1'b0;
        end else begin
            latch_reg      <= latch_next;
            latch_ovr_reg  <= latch_ovr_next;
            enc_reg        <= enc_next;
            enc_ovr_reg    <= enc_ovr_next;
            out_reg        <= out_next;
            out_ovr_reg    <= out_ovr_next;
            latch_full_reg <= latch_full_next;
            enc_full_reg   <= enc_full_next;
            valid_reg      <= valid_next;
        end
    end

    assign result_bits    = out_reg;
    assign overrange_flag = out_ovr_reg;
    assign result_valid   = valid_reg;

    // -----------------------------------------------------------------------
    // output buffers
    // -----------------------------------------------------------------------
    // enables bypass the clock on purpose so a shared bus can be released
    // at once; a floating pin has no pull and shows the inverse of its last driven level
    logic en_low_eff;
    logic en_high_eff;

    assign en_low_eff  = output_enable_low_active_drv ? output_enable_low_active : 1'b0;
    assign en_high_eff = output_enable_high_active_drv ? output_enable_high_active : 1'b1;

    assign result_oe         = {RES_W{en_high_eff}};
    assign overrange_flag_oe = en_high_eff && !en_low_eff;

    // -----------------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    phase_track_a: assert property (samp_clk |=> phase_reg == FADC_PH_BALANCE)
        else $error("phase not balance after clock high");
    aperture_delay_a: assert property (rise_evt |-> ##[AP_DLY:AP_DLY] ap_hit)
        else $error("aperture close not at fixed delay");
    latch_move_a: assert property (ap_hit |=> enc_reg == $countones($past(latch_reg)))
        else $error("latch contents not moved at sample");
    encode_count_a: assert property (enc_bus.code == RES_W'($countones(latch_reg)))
        else $error("thermometer code miscounted");
    code_saturate_a: assert property ((&latch_reg) |-> enc_bus.code == `FADC_CODE_TOP)
        else $error("full scale code not saturated");
    flag_separate_a: assert property (ap_hit ##1 1 |-> enc_ovr_reg == $past(latch_ovr_reg))
        else $error("overrange not from its own comparator");
    result_latency_a: assert property (
        fall_evt && enc_full_reg |=> result_bits == $past(enc_reg) && result_valid)
        else $error("result not presented at falling edge");
    // the top code bit must carry the half-scale weight of the comparator count
    msb_order_a: assert property (
        ap_hit |=> enc_reg[`FADC_RESULT_MSB] ==
            ($countones($past(latch_reg)) >= (1 << (RES_W - 1))))
        else $error("msb not on top bit");
    float_all_a: assert property (!en_high_eff |-> result_oe == '0 && !overrange_flag_oe)
        else $error("outputs driven while disabled");
    pull_default_a: assert property (
        !output_enable_low_active_drv && !output_enable_high_active_drv
        |-> result_oe == '1 && overrange_flag_oe)
        else $error("unconnected enables do not enable");
    first_valid_a: assert property (!enc_full_reg |=> !result_valid)
        else $error("result valid before first conversion");

    ovr_seen_c:   cover property (fall_evt && enc_ovr_reg && enc_reg == `FADC_CODE_TOP);
    first_conv_c: cover property ($rose(result_valid));
    float_c:      cover property (!en_high_eff ##1 en_high_eff && !en_low_eff);
    flag_off_c:   cover property (en_high_eff && en_low_eff && result_valid);
endmodule // fadc_port
